// *** include/sysctl_params.svh ***
// Purpose: Offsets, field positions, reset values and counts of sysctl
// Assumes: 32-bit classic Wishbone, byte addresses in the low 8 bits
// Notes:   Definitions only
`ifndef SYSCTL_PARAMS_SVH
`define SYSCTL_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_CLK_CTRL    8'h00
`define OFS_IRQ_STATUS  8'h04
`define OFS_IRQ_MASK    8'h08
`define OFS_IRQ_CTRL    8'h0c
`define OFS_VECTOR      8'h10
`define OFS_IDENTIFY    8'h14
`define OFS_RST_CAUSE   8'h18

// ****************************************
// Clock control fields
// ****************************************
`define F_CDS_LO        0
`define F_LPDE          2
`define F_SWITCHBACK    3
`define F_AUTO_XTAL     4
`define F_HALT          5
`define F_RST_PIN_DIS   6
`define F_BO_STOP_DIS   7
`define F_ON_RING       16
`define F_WARMING       17
`define F_DIV256        18
`define F_STOPPED       19

// ****************************************
// Interrupt control fields
// ****************************************
`define F_GLOBAL_EN     0
`define F_SYS_EN        1
`define F_PER_EN        2

// ****************************************
// Reset values and counts
// ****************************************
`define VECTOR_RST      16'h0000
`define FETCH_ADDR      16'h8000
`define WARMUP_OSC      65536
`define DIV256_LIMIT    8'hff
`define NUM_IRQ         8

`endif

// *** include/sysctl_pkg.sv ***
// Purpose: Types shared by the system control block
// Assumes: Constants come from sysctl_params.svh
// Notes:   Bus carriers follow classic Wishbone
package sysctl_pkg;

  // ****************************************
  // State encodings
  // ****************************************
  typedef enum logic [1:0] {
    PS_RESET = 2'b00,
    PS_RUN   = 2'b01,
    PS_STOP  = 2'b11
  } pwr_e;

  typedef enum logic {
    SRC_RING = 1'b0,
    SRC_XTAL = 1'b1
  } clk_src_e;

  // ****************************************
  // Bus carriers
  // ****************************************
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

endpackage

// *** verilog/pin_sync3.sv ***
// Purpose: Three-stage synchroniser for asynchronous pins
// Assumes: Inputs come from outside the clk domain
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ns
module pin_sync3 #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Pins
  input  wire logic [WIDTH-1:0] pin_in,
  // Filtered levels
  output logic      [WIDTH-1:0] level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } sync_s;

  sync_s s_ff;
  sync_s nxt_s;

  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync3: WIDTH must be at least 1");
  end

  always_comb begin
    nxt_s     = s_ff;
    nxt_s.s1  = pin_in;
    nxt_s.s2  = s_ff.s1;
    nxt_s.s3  = s_ff.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s_ff.s2[i] == s_ff.s3[i]) nxt_s.lvl[i] = s_ff.s3[i];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) s_ff <= '0;
    else      s_ff <= nxt_s;
  end

  assign level = s_ff.lvl;
endmodule // pin_sync3

// *** verilog/cycle_divider.sv ***
// Purpose: Counts oscillator ticks into core cycle pulses
// Assumes: tick is a one-cycle pulse on clk
// Notes:   boundary is high between core cycles
`timescale 1ns/1ns
module cycle_divider #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Control
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] limit,
  // Status
  output logic                  cycle,
  output logic                  boundary
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             cyc;
  } div_s;

  div_s s_ff;
  div_s nxt_s;

  if (WIDTH < 8) begin : g_width_check
    $error("cycle_divider: WIDTH must be at least 8");
  end

  always_comb begin
    nxt_s     = s_ff;
    nxt_s.cyc = 1'b0;
    if (!run) begin
      nxt_s.cnt = '0;
    end else if (tick) begin
      if (s_ff.cnt >= limit) begin
        nxt_s.cnt = '0;
        nxt_s.cyc = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) s_ff <= '0;
    else      s_ff <= nxt_s;
  end

  assign cycle    = s_ff.cyc;
  assign boundary = (s_ff.cnt == '0);
endmodule // cycle_divider

// *** verilog/sysctl.sv ***
// Purpose: Clock, power, reset and interrupt control of a small MCU
// Assumes: Oscillators and pins arrive asynchronously on clk
// Notes:   Core cycles are issued as one-cycle pulses on core_cycle
`timescale 1ns/1ns
`include "sysctl_params.svh"

module sysctl
  import sysctl_pkg::*;
#(
  parameter int WARMUP_CNT = `WARMUP_OSC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Register bus
  input  wire sysctl_pkg::wb_req_s wb_req,
  output sysctl_pkg::wb_rsp_s      wb_rsp,
  // Oscillators and pins
  input  wire logic              xtal_osc,
  input  wire logic              ring_osc,
  input  wire logic              ext_int_pin,
  input  wire logic              reset_pin_n,
  input  wire logic              supply_ok,
  // Internal interrupt events
  input  wire logic [7:0]        irq_event,
  // Core side
  output logic                   core_cycle,
  output logic                   core_reset,
  output logic                   fetch_load,
  output logic [15:0]            fetch_addr,
  output logic [15:0]            vector_address,
  output logic                   irq,
  // Oscillator control and status
  output logic                   xtal_enable,
  output logic                   on_ring,
  output logic                   divide_256_mode,
  output logic                   stopped
);
  import sysctl_pkg::*;

  localparam int WW = $clog2(WARMUP_CNT + 1);
  localparam logic [WW-1:0] WLAST = WW'(WARMUP_CNT - 1);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    pwr_e        pstate;
    clk_src_e    src;
    logic [7:0]  lim;
    logic [1:0]  clock_divide_select;
    logic        low_power_divide_enable;
    logic        switchback;
    logic        auto_xtal;
    logic        reset_pin_disable;
    logic        bo_stop_dis;
    logic [7:0]  flag;
    logic [7:0]  mask;
    logic        gie;
    logic        sys_en;
    logic        per_en;
    logic [15:0] vec;
    logic [2:0]  cause;
    logic        warm;
    logic [WW-1:0] wcnt;
    logic        xrdy;
    logic [4:0]  pin;
    logic        ack;
    logic [31:0] rdat;
    logic        fetch;
  } ctl_s;

  localparam ctl_s RST_STATE = '{
    pstate:                  PS_RESET,
    src:                     SRC_RING,
    lim:                     8'h00,
    clock_divide_select:     2'h0,
    low_power_divide_enable: 1'b0,
    switchback:              1'b0,
    auto_xtal:               1'b0,
    reset_pin_disable:       1'b0,
    bo_stop_dis:             1'b0,
    flag:                    8'h00,
    mask:                    8'h00,
    gie:                     1'b0,
    sys_en:                  1'b0,
    per_en:                  1'b0,
    vec:                     `VECTOR_RST,
    cause:                   3'h0,
    warm:                    1'b1,
    wcnt:                    '0,
    xrdy:                    1'b0,
    pin:                     5'h00,
    ack:                     1'b0,
    rdat:                    32'h0000_0000,
    fetch:                   1'b0
  };

  ctl_s s_ff;
  ctl_s nxt_s;

  logic [4:0] lvl;
  logic       div_cycle;
  logic       div_bound;
  logic       div_tick;

  if (WARMUP_CNT < 2) begin : g_warm_check
    $error("sysctl: WARMUP_CNT must be at least 2");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] div_limit(input logic [1:0] cds,
                                           input logic       lpde);
    if (lpde && cds == 2'h0) div_limit = `DIV256_LIMIT;
    else                     div_limit = 8'((8'h01 << cds) - 8'h01);
  endfunction

  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] dat,
                                       input logic [3:0]  sel);
    wr16 = old;
    if (sel[0]) wr16[7:0]  = dat[7:0];
    if (sel[1]) wr16[15:8] = dat[15:8];
  endfunction

  // ****************************************
  // Pin synchronisers and divider
  // ****************************************
  pin_sync3 #(
    .WIDTH (5)
  ) u_sync (
    .clk    (clk),
    .srst   (srst),
    .pin_in ({supply_ok, reset_pin_n, ext_int_pin, ring_osc, xtal_osc}),
    .level  (lvl)
  );

  assign div_tick = (s_ff.src == SRC_XTAL) ? (lvl[0] & ~s_ff.pin[0])
                                           : (lvl[1] & ~s_ff.pin[1]);

  cycle_divider #(
    .WIDTH (8)
  ) u_div (
    .clk      (clk),
    .srst     (srst),
    .run      (s_ff.pstate == PS_RUN),
    .tick     (div_tick),
    .limit    (s_ff.lim),
    .cycle    (div_cycle),
    .boundary (div_bound)
  );

  // ****************************************
  // Next state
  // ****************************************
  logic        xt_rise;
  logic        ext_fall;
  logic        por_evt;
  logic        bo_hold;
  logic        pin_hold;
  logic [7:0]  ev;
  logic [7:0]  clr;
  logic        acc;
  logic        wr;
  logic        sys_pend;
  logic        per_pend;
  logic [31:0] rd;

  always_comb begin
    nxt_s    = s_ff;
    nxt_s.ack   = 1'b0;
    nxt_s.fetch = 1'b0;
    nxt_s.pin   = lvl;
    xt_rise  = lvl[0] & ~s_ff.pin[0];
    ext_fall = ~lvl[2] & s_ff.pin[2];
    por_evt  = lvl[4] & ~s_ff.pin[4];
    bo_hold  = ~lvl[4] & ~(s_ff.pstate == PS_STOP && s_ff.bo_stop_dis);
    pin_hold = ~lvl[3] & ~s_ff.reset_pin_disable;
    ev       = irq_event | {6'h00, ext_fall, 1'b0};
    acc      = wb_req.cyc & wb_req.stb & ~s_ff.ack;
    wr       = acc & wb_req.we;
    clr      = 8'h00;
    sys_pend = s_ff.flag[0] & s_ff.mask[0] & s_ff.sys_en;
    per_pend = |(s_ff.flag[7:1] & s_ff.mask[7:1]) & s_ff.per_en;

    // Bus reads
    rd = 32'h0000_0000;
    unique case (wb_req.adr)
      `OFS_CLK_CTRL: begin
        rd[`F_CDS_LO+1:`F_CDS_LO] = s_ff.clock_divide_select;
        rd[`F_LPDE]        = s_ff.low_power_divide_enable;
        rd[`F_SWITCHBACK]  = s_ff.switchback;
        rd[`F_AUTO_XTAL]   = s_ff.auto_xtal;
        rd[`F_RST_PIN_DIS] = s_ff.reset_pin_disable;
        rd[`F_BO_STOP_DIS] = s_ff.bo_stop_dis;
        rd[`F_ON_RING]     = (s_ff.src == SRC_RING);
        rd[`F_WARMING]     = s_ff.warm;
        rd[`F_DIV256]      = (s_ff.lim == `DIV256_LIMIT);
        rd[`F_STOPPED]     = (s_ff.pstate == PS_STOP);
      end
      `OFS_IRQ_STATUS: begin
        rd[7:0] = s_ff.flag;
        if (acc && !wb_req.we) clr = s_ff.flag;
      end
      `OFS_IRQ_MASK:   rd[7:0] = s_ff.mask;
      `OFS_IRQ_CTRL:   rd[2:0] = {s_ff.per_en, s_ff.sys_en, s_ff.gie};
      `OFS_VECTOR:     rd[15:0] = s_ff.vec;
      `OFS_IDENTIFY:   rd[1:0] = {per_pend, sys_pend};
      `OFS_RST_CAUSE:  rd[2:0] = s_ff.cause;
      default:         rd = 32'h0000_0000;
    endcase
    if (acc) begin
      nxt_s.ack  = 1'b1;
      nxt_s.rdat = wb_req.we ? 32'h0000_0000 : rd;
    end

    // Bus writes
    if (wr && wb_req.sel[0]) begin
      unique case (wb_req.adr)
        `OFS_CLK_CTRL: begin
          nxt_s.clock_divide_select =
            wb_req.dat[`F_CDS_LO+1:`F_CDS_LO];
          nxt_s.low_power_divide_enable = wb_req.dat[`F_LPDE];
          nxt_s.switchback        = wb_req.dat[`F_SWITCHBACK];
          nxt_s.auto_xtal         = wb_req.dat[`F_AUTO_XTAL];
          nxt_s.reset_pin_disable = wb_req.dat[`F_RST_PIN_DIS];
          nxt_s.bo_stop_dis       = wb_req.dat[`F_BO_STOP_DIS];
          if (wb_req.dat[`F_HALT] && s_ff.pstate == PS_RUN) begin
            nxt_s.pstate = PS_STOP;
            nxt_s.warm   = 1'b0;
            nxt_s.xrdy   = 1'b0;
            nxt_s.wcnt   = '0;
          end
        end
        `OFS_IRQ_MASK: nxt_s.mask = wb_req.dat[7:0];
        `OFS_IRQ_CTRL: begin
          nxt_s.gie    = wb_req.dat[`F_GLOBAL_EN];
          nxt_s.sys_en = wb_req.dat[`F_SYS_EN];
          nxt_s.per_en = wb_req.dat[`F_PER_EN];
        end
        `OFS_RST_CAUSE: clr = 8'h00;
        default: clr = clr;
      endcase
    end
    if (wr && wb_req.adr == `OFS_VECTOR) begin
      nxt_s.vec = wr16(s_ff.vec, wb_req.dat, wb_req.sel);
    end
    if (wr && wb_req.adr == `OFS_RST_CAUSE && wb_req.sel[0]) begin
      nxt_s.cause = s_ff.cause & ~wb_req.dat[2:0];
    end

    // Interrupt flags, set wins over clear
    nxt_s.flag = (s_ff.flag & ~clr) | ev;

    // Switchback out of divide-by-256
    if (s_ff.switchback && s_ff.lim == `DIV256_LIMIT &&
        |(ev & s_ff.mask)) begin
      nxt_s.low_power_divide_enable = 1'b0;
    end

    // Crystal warm-up
    if (s_ff.warm && xt_rise && s_ff.pstate != PS_STOP) begin
      if (s_ff.wcnt == WLAST) begin
        nxt_s.warm = 1'b0;
        nxt_s.xrdy = 1'b1;
      end else begin
        nxt_s.wcnt = s_ff.wcnt + 1'b1;
      end
    end

    // Source and divider change on whole core cycles only
    if (div_bound && !div_tick) begin
      nxt_s.src = (s_ff.xrdy && s_ff.auto_xtal) ? SRC_XTAL
                                                : SRC_RING;
      nxt_s.lim = div_limit(nxt_s.clock_divide_select,
                            nxt_s.low_power_divide_enable);
    end

    // Power state
    unique case (s_ff.pstate)
      PS_RESET: begin
        if (!bo_hold && !pin_hold && !por_evt) begin
          nxt_s.pstate = PS_RUN;
          nxt_s.fetch  = 1'b1;
        end
      end
      PS_RUN: begin
        if (bo_hold || pin_hold) nxt_s.pstate = PS_RESET;
      end
      PS_STOP: begin
        if (pin_hold || bo_hold) begin
          nxt_s.pstate = PS_RESET;
        end else if ((ext_fall && s_ff.mask[1]) ||
                     (irq_event[7] && s_ff.mask[7])) begin
          nxt_s.pstate = PS_RUN;
        end
        if (nxt_s.pstate != PS_STOP) begin
          nxt_s.src  = SRC_RING;
          nxt_s.lim  = div_limit(s_ff.clock_divide_select,
                                 s_ff.low_power_divide_enable);
          nxt_s.warm = 1'b1;
          nxt_s.wcnt = '0;
        end
      end
      default: nxt_s.pstate = PS_RESET;
    endcase

    // Reset causes
    if (bo_hold && s_ff.pstate != PS_RESET) nxt_s.cause[1] = 1'b1;
    if (pin_hold && s_ff.pstate != PS_RESET) nxt_s.cause[2] = 1'b1;

    // Power-on reset
    if (por_evt) begin
      nxt_s          = RST_STATE;
      nxt_s.pin      = lvl;
      nxt_s.cause    = 3'b001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) s_ff <= RST_STATE;
    else      s_ff <= nxt_s;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_rsp.ack      = s_ff.ack;
  assign wb_rsp.dat      = s_ff.rdat;
  assign core_cycle      = div_cycle & (s_ff.pstate == PS_RUN);
  assign core_reset      = (s_ff.pstate == PS_RESET);
  assign fetch_load      = s_ff.fetch;
  assign fetch_addr      = `FETCH_ADDR;
  assign vector_address  = s_ff.vec;
  assign irq             = s_ff.gie & (sys_pend | per_pend);
  assign xtal_enable     = (s_ff.pstate != PS_STOP);
  assign on_ring         = (s_ff.src == SRC_RING);
  assign divide_256_mode = (s_ff.lim == `DIV256_LIMIT);
  assign stopped         = (s_ff.pstate == PS_STOP);
endmodule // sysctl

// *** bench/sysctl_monitor.sv ***
// Purpose: Port-level checks of sysctl
// Assumes: One clock domain, srst synchronous active high
// Notes:   Attached to every sysctl by bind
`timescale 1ns/1ns
module sysctl_monitor
  import sysctl_pkg::*;
(
  // Clock and reset
  input wire logic                clk,
  input wire logic                srst,
  // Register bus
  input wire sysctl_pkg::wb_req_s wb_req,
  input wire sysctl_pkg::wb_rsp_s wb_rsp,
  // Events and core side
  input wire logic [7:0]          irq_event,
  input wire logic                core_cycle,
  input wire logic                core_reset,
  input wire logic                fetch_load,
  input wire logic [15:0]         fetch_addr,
  input wire logic [15:0]         vector_address,
  input wire logic                irq,
  // Oscillator status
  input wire logic                xtal_enable,
  input wire logic                on_ring,
  input wire logic                stopped
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack lasted more than one cycle");
  chk_ack_latency: assert property (
    wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("request not answered after one cycle");
  chk_write_zero: assert property (
    wb_rsp.ack && wb_req.we |-> wb_rsp.dat == 32'h0)
    else $error("write answer carries data");
  chk_vector_reset: assert property (
    $past(srst) |-> vector_address == 16'h0000)
    else $error("vector not cleared by reset");
  chk_reset_state: assert property (
    $past(srst) |-> core_reset && on_ring)
    else $error("reset state not entered on ring");
  chk_fetch_start: assert property (
    fetch_load |-> fetch_addr == 16'h8000 ##1 !fetch_load)
    else $error("fetch start wrong");
  chk_stop_halts: assert property (
    stopped && $past(stopped) |-> !core_cycle && !xtal_enable)
    else $error("activity during stop");
  chk_reset_osc: assert property (core_reset |-> xtal_enable)
    else $error("crystal halted in reset");
  chk_reset_halts: assert property (
    core_reset && $past(core_reset) |-> !core_cycle)
    else $error("core cycle during reset");
  chk_wake_ring: assert property ($fell(stopped) |-> on_ring)
    else $error("stop left without ring clock");
  chk_clear_drops: assert property (
    wb_rsp.ack && !wb_req.we && wb_req.adr == 8'h04 &&
    $past(irq_event) == 8'h00 |-> !irq)
    else $error("irq stays after status clear");
endmodule // sysctl_monitor

bind sysctl sysctl_monitor sysctl_monitor_i (
  .clk(clk), .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp),
  .irq_event(irq_event), .core_cycle(core_cycle),
  .core_reset(core_reset), .fetch_load(fetch_load),
  .fetch_addr(fetch_addr), .vector_address(vector_address),
  .irq(irq), .xtal_enable(xtal_enable), .on_ring(on_ring),
  .stopped(stopped));

// *** bench/osc_model.sv ***
// Purpose: Ring and crystal oscillator sources
// Assumes: Ring period 11 clk, crystal period 9 clk
// Notes:   Crystal stands still while not enabled
`timescale 1ns/1ns
module osc_model (
  // Control
  input  wire logic xtal_enable,
  // Oscillators
  output logic      xtal_osc,
  output logic      ring_osc
);
  initial begin
    ring_osc = 1'b0;
    #13;
    forever #550 ring_osc = ~ring_osc;
  end
  initial begin
    xtal_osc = 1'b0;
    #7;
    forever begin
      #450;
      if (xtal_enable) xtal_osc = ~xtal_osc;
      else xtal_osc = 1'b0;
    end
  end
endmodule // osc_model

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench of the system control block
// Assumes: Oscillators from osc_model, warm-up shortened to 8
// Notes:   Register cases in rows, awkward cases after them
`timescale 1ns/1ns
`include "sysctl_params.svh"
module tb_top;
  import sysctl_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] wdat, mask, exp;
  } row_s;
  localparam int WARM = 8;
  logic        clk, srst, ext_int_pin, reset_pin_n, supply_ok;
  logic        xtal_osc, ring_osc, xtal_enable, on_ring, stopped;
  logic        core_cycle, core_reset, fetch_load, irq, divide_256_mode;
  logic [15:0] fetch_addr, vector_address;
  logic [7:0]  irq_event;
  logic [5:0]  sigs;
  wb_req_s     wb_req;
  wb_rsp_s     wb_rsp;
  row_s        rows [7];
  int          bad_count, checks_done, xtal_edges;
  assign sigs = {core_cycle, divide_256_mode, fetch_load, core_reset,
                 on_ring, stopped};
  sysctl #(.WARMUP_CNT(WARM)) sysctl_i (
    .clk(clk), .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .xtal_osc(xtal_osc), .ring_osc(ring_osc), .ext_int_pin(ext_int_pin),
    .reset_pin_n(reset_pin_n), .supply_ok(supply_ok),
    .irq_event(irq_event), .core_cycle(core_cycle),
    .core_reset(core_reset), .fetch_load(fetch_load),
    .fetch_addr(fetch_addr), .vector_address(vector_address), .irq(irq),
    .xtal_enable(xtal_enable), .on_ring(on_ring),
    .divide_256_mode(divide_256_mode), .stopped(stopped));
  osc_model osc_model_i (.xtal_enable(xtal_enable), .xtal_osc(xtal_osc),
                         .ring_osc(ring_osc));
  initial clk = 1'b0;
  always #50 clk = ~clk;
  always @(posedge xtal_osc) xtal_edges++;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdat);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: wd};
    do begin
      @(posedge clk);
    end while (wb_rsp.ack !== 1'b1);
    rdat = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    cmp(d & m, e);
  endtask
  task automatic wait_sig(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (sigs[s] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    cmp({31'h0, sigs[s]}, {31'h0, v});
  endtask
  task automatic pulse(input int i);
    irq_event <= 8'h01 << i;
    @(posedge clk);
    irq_event <= 8'h00;
    @(posedge clk);
  endtask
  task automatic meas(output int n);
    n = 0;
    while (core_cycle !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (core_cycle !== 1'b1 && n < 4000);
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    int n;
    rows = '{'{`OFS_VECTOR, 32'h1234, 32'hffff, 32'h1234},
             '{8'h1c, 32'hffffffff, 32'hffffffff, 32'h0},
             '{`OFS_IDENTIFY, 32'hff, 32'h3, 32'h0},
             '{`OFS_CLK_CTRL, 32'h000f0003, 32'h000d00ff, 32'h00010003},
             '{`OFS_IRQ_MASK, 32'hff, 32'hff, 32'hff},
             '{`OFS_IRQ_CTRL, 32'h7, 32'h7, 32'h7},
             '{`OFS_RST_CAUSE, 32'h7, 32'h7, 32'h0}};
    srst = 1'b1;
    wb_req = '0;
    irq_event = 8'h00;
    ext_int_pin = 1'b1;
    reset_pin_n = 1'b1;
    supply_ok = 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    wait_sig(3, 1'b1, 40);
    cmp({16'h0, fetch_addr}, 32'h8000);
    rd(`OFS_RST_CAUSE, 32'h7, 32'h1);
    rd(`OFS_CLK_CTRL, 32'h100ff, 32'h10000);
    rd(`OFS_VECTOR, 32'hffff, 32'h0);
    foreach (rows[k]) begin
      wr(rows[k].adr, rows[k].wdat);
      rd(rows[k].adr, rows[k].mask, rows[k].exp);
    end
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      cmp({31'h0, irq}, 32'h1);
      rd(`OFS_IDENTIFY, 32'h3, (i == 0) ? 32'h1 : 32'h2);
      rd(`OFS_IRQ_STATUS, 32'hff, 32'h1 << i);
      cmp({31'h0, irq}, 32'h0);
    end
    wr(`OFS_IRQ_CTRL, 32'h6);
    pulse(4);
    cmp({31'h0, irq}, 32'h0);
    rd(`OFS_IRQ_STATUS, 32'hff, 32'h10);
    wr(`OFS_IRQ_CTRL, 32'h5);
    pulse(0);
    cmp({31'h0, irq}, 32'h0);
    rd(`OFS_IRQ_STATUS, 32'hff, 32'h1);
    wr(`OFS_IRQ_CTRL, 32'h7);
    wr(`OFS_IRQ_MASK, 32'h7f);
    pulse(7);
    cmp({31'h0, irq}, 32'h0);
    rd(`OFS_IRQ_STATUS, 32'hff, 32'h80);
    wr(`OFS_IRQ_MASK, 32'hff);
    for (int j = 0; j < 4; j++) begin
      wr(`OFS_CLK_CTRL, j);
      meas(n);
      meas(n);
      cmp(n, 11 << j);
    end
    wr(`OFS_CLK_CTRL, 32'h4);
    meas(n);
    meas(n);
    cmp(n, 32'd2816);
    cmp({31'h0, divide_256_mode}, 32'h1);
    wr(`OFS_CLK_CTRL, 32'hc);
    pulse(2);
    wait_sig(4, 1'b0, 3000);
    rd(`OFS_CLK_CTRL, 32'h4, 32'h0);
    rd(`OFS_IRQ_STATUS, 32'hff, 32'h4);
    wr(`OFS_CLK_CTRL, 32'h10);
    wait_sig(1, 1'b0, 400);
    meas(n);
    meas(n);
    cmp(n, 32'd9);
    wr(`OFS_CLK_CTRL, 32'h30);
    wait_sig(0, 1'b1, 60);
    cmp({31'h0, xtal_enable}, 32'h0);
    repeat (20) @(posedge clk);
    pulse(3);
    repeat (10) @(posedge clk);
    cmp({31'h0, stopped}, 32'h1);
    ext_int_pin <= 1'b0;
    wait_sig(0, 1'b0, 20);
    xtal_edges = 0;
    cmp({31'h0, on_ring}, 32'h1);
    rd(`OFS_CLK_CTRL, 32'h20000, 32'h20000);
    wait_sig(5, 1'b1, 40);
    wait_sig(1, 1'b0, 300);
    cmp(xtal_edges >= WARM && xtal_edges <= WARM + 3, 32'h1);
    ext_int_pin <= 1'b1;
    rd(`OFS_IRQ_STATUS, 32'h2, 32'h2);
    wr(`OFS_CLK_CTRL, 32'h30);
    wait_sig(0, 1'b1, 60);
    pulse(7);
    wait_sig(0, 1'b0, 20);
    wr(`OFS_CLK_CTRL, 32'h30);
    wait_sig(0, 1'b1, 60);
    reset_pin_n <= 1'b0;
    wait_sig(2, 1'b1, 20);
    reset_pin_n <= 1'b1;
    wait_sig(3, 1'b1, 40);
    rd(`OFS_RST_CAUSE, 32'h4, 32'h4);
    wr(`OFS_CLK_CTRL, 32'h40);
    reset_pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    cmp({31'h0, core_reset}, 32'h0);
    reset_pin_n <= 1'b1;
    wr(`OFS_VECTOR, 32'hbeef);
    wr(`OFS_CLK_CTRL, 32'ha0);
    wait_sig(0, 1'b1, 60);
    supply_ok <= 1'b0;
    repeat (10) @(posedge clk);
    cmp({31'h0, core_reset}, 32'h0);
    pulse(7);
    wait_sig(2, 1'b1, 20);
    rd(`OFS_RST_CAUSE, 32'h2, 32'h2);
    supply_ok <= 1'b1;
    wait_sig(3, 1'b1, 40);
    rd(`OFS_RST_CAUSE, 32'h1, 32'h1);
    rd(`OFS_CLK_CTRL, 32'h10040, 32'h10000);
    cmp({16'h0, vector_address}, 32'h0);
    tally_and_finish();
  end
endmodule // tb_top
